/* File: core/pmd_consts.svh */
// pmd_consts.svh: register offsets, field positions and reset values
// assumes a 5-bit host offset and 8-bit registers on the local bus
// Behaviour
// - every register is eight bits wide except 19h, which holds four; only the data port is wider.
// - data port is 8 or 16 bits, chosen by word transfer select.
// - offsets 01h to 0Fh decode through the current page, others never.
// - page select is command bits 7:6, codes 00 to 11 give pages 0 to 3.
// - offset 17h reads device state, writes go to jam limit count.
// - reading 1Fh fires software reset, writing 1Fh goes to host wakeup.
// - 1Ch reads tx end page, writes vlan id low; 1Dh writes vlan high.
// - 1Eh writes the byte order register, reads are reserved.
// - page 0 offset 04h reads tx status, writes tx page start.
// - page 0 05h/06h write tx byte count, read collisions and rx page.
// - page 0 08h/09h write remote start, read current remote address.
// - page 0 0Ah/0Bh write remote byte count, reads reserved.
// - page 0 0Ch-0Fh read rx status and tallies, write configs and mask.
// - page 0 offset 07h is the interrupt flag register, read and write.
// - page 1 offsets 01h-06h hold six station address bytes.
// - page 1 offset 07h is the current receive page, read and write.
// - page 1 offsets 08h-0Fh hold eight multicast hash bytes.
// - max frame size is 12 bits, low byte at 18h, bits 11:8 at 19h.
`ifndef PMD_CONSTS_SVH
`define PMD_CONSTS_SVH
`define PMD_OFS_CMD 5'h00
`define PMD_OFS_RX_START 5'h01
`define PMD_OFS_RX_STOP 5'h02
`define PMD_OFS_BOUNDARY 5'h03
`define PMD_OFS_TX_PAGE 5'h04
`define PMD_OFS_TX_CNT_LO 5'h05
`define PMD_OFS_TX_CNT_HI 5'h06
`define PMD_OFS_IRQ 5'h07
`define PMD_OFS_REM_LO 5'h08
`define PMD_OFS_REM_HI 5'h09
`define PMD_OFS_RBC_LO 5'h0A
`define PMD_OFS_RBC_HI 5'h0B
`define PMD_OFS_RX_CFG 5'h0C
`define PMD_OFS_TX_CFG 5'h0D
`define PMD_OFS_DATA_CFG 5'h0E
`define PMD_OFS_IRQ_MASK 5'h0F
`define PMD_OFS_PAGED_LAST 5'h0F
`define PMD_OFS_STATION_FIRST 5'h01
`define PMD_OFS_STATION_LAST 5'h06
`define PMD_OFS_RX_PAGE_P1 5'h07
`define PMD_OFS_MCAST_FIRST 5'h08
`define PMD_OFS_DP_EVEN 5'h10
`define PMD_OFS_DP_ODD 5'h11
`define PMD_OFS_IFG1 5'h12
`define PMD_OFS_IFG2 5'h13
`define PMD_OFS_MGMT 5'h14
`define PMD_OFS_BUFFER_TYPE_CONFIG 5'h15
`define PMD_OFS_IFG 5'h16
`define PMD_OFS_JAM 5'h17
`define PMD_OFS_MFS_LO 5'h18
`define PMD_OFS_MFS_HI 5'h19
`define PMD_OFS_FCR 5'h1A
`define PMD_OFS_MCR 5'h1B
`define PMD_OFS_VLAN_LO 5'h1C
`define PMD_OFS_VLAN_HI 5'h1D
`define PMD_OFS_BYTE_ORDER 5'h1E
`define PMD_OFS_WAKE 5'h1F
`define PMD_PS_MSB 7
`define PMD_PS_LSB 6
`define PMD_WTS_BIT 0
`define PMD_RST_CMD 8'h21
`define PMD_RST_BOUNDARY 8'h4C
`endif

/* File: core/pmd_pkg.sv */
// pmd_pkg: types of the paged register decoder
// assumes the constants header is included by users of offsets
package pmd_pkg;
  typedef enum logic [1:0] {
    PMD_PG0 = 2'b00, PMD_PG1 = 2'b01, PMD_PG2 = 2'b10, PMD_PG3 = 2'b11
  } pmd_page_e;
  typedef enum logic {PMD_BUS_IDLE = 1'b0, PMD_BUS_BUSY = 1'b1} pmd_bus_e;
  typedef struct packed {
    logic [7:0] command, rx_start, rx_stop, boundary, tx_page;
    logic [15:0] tx_cnt, rem_start, rem_cnt;
    logic [7:0] rx_cfg, tx_cfg, data_cfg, irq_mask;
    logic [5:0][7:0] station;
    logic [7:0][7:0] mcast;
    logic [7:0] ifg1, ifg2, mgmt, buffer_type_config, inter_frame_gap, jam;
    logic [11:0] mfs;
    logic [7:0] pause_flow_control, mac_config;
    logic [15:0] vlan;
    logic [7:0] byte_order;
  } pmd_cfg_s;
  typedef struct packed {
    logic [7:0] tx_status, collisions;
    logic [15:0] rem_cur;
    logic [7:0] rx_status, align, crc, lost, dev_state, tx_end_page;
    logic [7:0] irq_set;
    logic rx_page_load;
    logic [7:0] rx_page_val;
    logic [15:0] dp_rdata;
  } pmd_stat_s;
  typedef struct packed {
    pmd_bus_e bus;
    pmd_cfg_s cfg;
    logic [7:0] irq, rx_page;
    logic [15:0] dout;
    logic oe, dp_wr, dp_rd, swrst, wake;
    logic [15:0] dp_wdata;
  } pmd_state_s;
endpackage

/* File: core/pmd_regs.sv */
// pmd_regs: paged host register map of the mac core
// assumes host strobes synchronous to CLOCK, core status in CORE_STAT
`timescale 1ns/1ns
`include "pmd_consts.svh"
module pmd_regs (
  // clock and reset
  input wire logic CLOCK,
  input wire logic SYS_RST,
  // host local bus
  input wire logic HOST_CS_N,
  input wire logic HOST_RD_N,
  input wire logic HOST_WR_N,
  input wire logic [4:0] HOST_ADDR,
  input wire logic [15:0] HOST_DATA_IN,
  output logic [15:0] HOST_DATA_OUT,
  output logic HOST_DATA_OE,
  // mac core side
  input pmd_pkg::pmd_stat_s CORE_STAT,
  output pmd_pkg::pmd_cfg_s CFG,
  output logic [7:0] IRQ_FLAGS,
  output logic [7:0] RX_CUR_PAGE,
  output logic DP_WR_STB,
  output logic [15:0] DP_WDATA,
  output logic DP_RD_STB,
  output logic SOFT_RST_STB,
  output logic WAKE_STB
);
  import pmd_pkg::*;

  pmd_state_s s_q;
  pmd_state_s s_d;
  logic rd_req;
  logic wr_req;
  logic rd_start;
  logic wr_start;
  logic is_dp;
  logic word_transfer_select;
  logic [7:0] wd;
  logic [3:0] wnib;
  logic [7:0] irq_clr;
  pmd_page_e page;

  // byte seen by a host read at offset a
  function automatic logic [7:0] rd_byte(
    input logic [4:0] a,
    input pmd_page_e pg,
    input pmd_state_s s,
    input pmd_stat_s c
  );
    logic [7:0] v;
    v = 8'h00;
    if (a == `PMD_OFS_CMD) begin
      v = s.cfg.command;
    end else if (a <= `PMD_OFS_PAGED_LAST) begin
      if (pg == PMD_PG0) begin
        if (a == `PMD_OFS_RX_START) v = s.cfg.rx_start;
        else if (a == `PMD_OFS_RX_STOP) v = s.cfg.rx_stop;
        else if (a == `PMD_OFS_BOUNDARY) v = s.cfg.boundary;
        else if (a == `PMD_OFS_TX_PAGE) v = c.tx_status;
        else if (a == `PMD_OFS_TX_CNT_LO) v = c.collisions;
        else if (a == `PMD_OFS_TX_CNT_HI) v = s.rx_page;
        else if (a == `PMD_OFS_IRQ) v = s.irq;
        else if (a == `PMD_OFS_REM_LO) v = c.rem_cur[7:0];
        else if (a == `PMD_OFS_REM_HI) v = c.rem_cur[15:8];
        else if (a == `PMD_OFS_RX_CFG) v = c.rx_status;
        else if (a == `PMD_OFS_TX_CFG) v = c.align;
        else if (a == `PMD_OFS_DATA_CFG) v = c.crc;
        else if (a == `PMD_OFS_IRQ_MASK) v = c.lost;
        else v = 8'h00;
      end else if (pg == PMD_PG1) begin
        if (a <= `PMD_OFS_STATION_LAST) begin
          v = s.cfg.station[3'(a - `PMD_OFS_STATION_FIRST)];
        end else if (a == `PMD_OFS_RX_PAGE_P1) begin
          v = s.rx_page;
        end else begin
          v = s.cfg.mcast[3'(a - `PMD_OFS_MCAST_FIRST)];
        end
      end else begin
        v = 8'h00;
      end
    end else if (a == `PMD_OFS_IFG1) v = s.cfg.ifg1;
    else if (a == `PMD_OFS_IFG2) v = s.cfg.ifg2;
    else if (a == `PMD_OFS_MGMT) v = s.cfg.mgmt;
    else if (a == `PMD_OFS_BUFFER_TYPE_CONFIG) v = s.cfg.buffer_type_config;
    else if (a == `PMD_OFS_IFG) v = s.cfg.inter_frame_gap;
    else if (a == `PMD_OFS_JAM) v = c.dev_state;
    else if (a == `PMD_OFS_MFS_LO) v = s.cfg.mfs[7:0];
    else if (a == `PMD_OFS_MFS_HI) v = {4'h0, s.cfg.mfs[11:8]};
    else if (a == `PMD_OFS_FCR) v = s.cfg.pause_flow_control;
    else if (a == `PMD_OFS_MCR) v = s.cfg.mac_config;
    else if (a == `PMD_OFS_VLAN_LO) v = c.tx_end_page;
    else v = 8'h00;
    return v;
  endfunction

  assign rd_req = !HOST_CS_N && !HOST_RD_N;
  assign wr_req = !HOST_CS_N && !HOST_WR_N && HOST_RD_N;
  assign rd_start = rd_req && (s_q.bus == PMD_BUS_IDLE);
  assign wr_start = wr_req && (s_q.bus == PMD_BUS_IDLE);
  assign is_dp = (HOST_ADDR == `PMD_OFS_DP_EVEN) || (HOST_ADDR == `PMD_OFS_DP_ODD);
  assign word_transfer_select = s_q.cfg.data_cfg[`PMD_WTS_BIT];
  assign wd = HOST_DATA_IN[7:0];
  assign wnib = HOST_DATA_IN[3:0];
  assign page = pmd_page_e'(s_q.cfg.command[`PMD_PS_MSB:`PMD_PS_LSB]);
  assign irq_clr = (wr_start && page == PMD_PG0 && HOST_ADDR == `PMD_OFS_IRQ) ? wd : 8'h00;

  always_comb begin
    s_d = s_q;
    s_d.dp_wr = 1'b0;
    s_d.dp_rd = 1'b0;
    s_d.swrst = 1'b0;
    s_d.wake = 1'b0;
    s_d.bus = (rd_req || wr_req) ? PMD_BUS_BUSY : PMD_BUS_IDLE;
    // read path: capture once at start, hold while strobe stays low
    s_d.oe = rd_req;
    if (rd_start) begin
      if (is_dp) begin
        s_d.dout = word_transfer_select ? CORE_STAT.dp_rdata : {8'h00, CORE_STAT.dp_rdata[7:0]};
        s_d.dp_rd = 1'b1;
      end else begin
        s_d.dout = {8'h00, rd_byte(HOST_ADDR, page, s_q, CORE_STAT)};
      end
      s_d.swrst = (HOST_ADDR == `PMD_OFS_WAKE);
    end else if (!rd_req) begin
      s_d.dout = 16'h0000;
    end
    // write path, only the low byte lands in 8-bit registers
    if (wr_start) begin
      if (HOST_ADDR == `PMD_OFS_CMD) begin
        s_d.cfg.command = wd;
      end else if (HOST_ADDR <= `PMD_OFS_PAGED_LAST) begin
        if (page == PMD_PG0) begin
          if (HOST_ADDR == `PMD_OFS_RX_START) s_d.cfg.rx_start = wd;
          else if (HOST_ADDR == `PMD_OFS_RX_STOP) s_d.cfg.rx_stop = wd;
          else if (HOST_ADDR == `PMD_OFS_BOUNDARY) s_d.cfg.boundary = wd;
          else if (HOST_ADDR == `PMD_OFS_TX_PAGE) s_d.cfg.tx_page = wd;
          else if (HOST_ADDR == `PMD_OFS_TX_CNT_LO) s_d.cfg.tx_cnt[7:0] = wd;
          else if (HOST_ADDR == `PMD_OFS_TX_CNT_HI) s_d.cfg.tx_cnt[15:8] = wd;
          else if (HOST_ADDR == `PMD_OFS_REM_LO) s_d.cfg.rem_start[7:0] = wd;
          else if (HOST_ADDR == `PMD_OFS_REM_HI) s_d.cfg.rem_start[15:8] = wd;
          else if (HOST_ADDR == `PMD_OFS_RBC_LO) s_d.cfg.rem_cnt[7:0] = wd;
          else if (HOST_ADDR == `PMD_OFS_RBC_HI) s_d.cfg.rem_cnt[15:8] = wd;
          else if (HOST_ADDR == `PMD_OFS_RX_CFG) s_d.cfg.rx_cfg = wd;
          else if (HOST_ADDR == `PMD_OFS_TX_CFG) s_d.cfg.tx_cfg = wd;
          else if (HOST_ADDR == `PMD_OFS_DATA_CFG) s_d.cfg.data_cfg = wd;
          else if (HOST_ADDR == `PMD_OFS_IRQ_MASK) s_d.cfg.irq_mask = wd;
        end else if (page == PMD_PG1) begin
          if (HOST_ADDR <= `PMD_OFS_STATION_LAST) begin
            s_d.cfg.station[3'(HOST_ADDR - `PMD_OFS_STATION_FIRST)] = wd;
          end else if (HOST_ADDR == `PMD_OFS_RX_PAGE_P1) begin
            s_d.rx_page = wd;
          end else begin
            s_d.cfg.mcast[3'(HOST_ADDR - `PMD_OFS_MCAST_FIRST)] = wd;
          end
        end
      end else if (is_dp) begin
        s_d.dp_wr = 1'b1;
        s_d.dp_wdata = word_transfer_select ? HOST_DATA_IN : {8'h00, wd};
      end else if (HOST_ADDR == `PMD_OFS_IFG1) s_d.cfg.ifg1 = wd;
      else if (HOST_ADDR == `PMD_OFS_IFG2) s_d.cfg.ifg2 = wd;
      else if (HOST_ADDR == `PMD_OFS_MGMT) s_d.cfg.mgmt = wd;
      else if (HOST_ADDR == `PMD_OFS_BUFFER_TYPE_CONFIG) s_d.cfg.buffer_type_config = wd;
      else if (HOST_ADDR == `PMD_OFS_IFG) s_d.cfg.inter_frame_gap = wd;
      else if (HOST_ADDR == `PMD_OFS_JAM) s_d.cfg.jam = wd;
      else if (HOST_ADDR == `PMD_OFS_MFS_LO) s_d.cfg.mfs[7:0] = wd;
      else if (HOST_ADDR == `PMD_OFS_MFS_HI) s_d.cfg.mfs[11:8] = wnib;
      else if (HOST_ADDR == `PMD_OFS_FCR) s_d.cfg.pause_flow_control = wd;
      else if (HOST_ADDR == `PMD_OFS_MCR) s_d.cfg.mac_config = wd;
      else if (HOST_ADDR == `PMD_OFS_VLAN_LO) s_d.cfg.vlan[7:0] = wd;
      else if (HOST_ADDR == `PMD_OFS_VLAN_HI) s_d.cfg.vlan[15:8] = wd;
      else if (HOST_ADDR == `PMD_OFS_BYTE_ORDER) s_d.cfg.byte_order = wd;
      else if (HOST_ADDR == `PMD_OFS_WAKE) s_d.wake = 1'b1;
    end
    // flags: write one clears, a new event in the same cycle wins
    s_d.irq = (s_q.irq & ~irq_clr) | CORE_STAT.irq_set;
    // core advancing the receive page overrides a host write
    if (CORE_STAT.rx_page_load) begin
      s_d.rx_page = CORE_STAT.rx_page_val;
    end
    if (SYS_RST) begin
      s_d = '0;
      s_d.cfg.command = `PMD_RST_CMD;
      s_d.cfg.boundary = `PMD_RST_BOUNDARY;
    end
  end

  always_ff @(posedge CLOCK) begin
    s_q <= s_d;
  end

  assign HOST_DATA_OUT = s_q.dout;
  assign HOST_DATA_OE = s_q.oe;
  assign CFG = s_q.cfg;
  assign IRQ_FLAGS = s_q.irq;
  assign RX_CUR_PAGE = s_q.rx_page;
  assign DP_WR_STB = s_q.dp_wr;
  assign DP_WDATA = s_q.dp_wdata;
  assign DP_RD_STB = s_q.dp_rd;
  assign SOFT_RST_STB = s_q.swrst;
  assign WAKE_STB = s_q.wake;

  // checks
  logic [15:0] dp_rdata;
  logic [7:0] dsr;
  logic [7:0] txs;
  assign dp_rdata = CORE_STAT.dp_rdata;
  assign dsr = CORE_STAT.dev_state;
  assign txs = CORE_STAT.tx_status;

  default clocking cb @(posedge CLOCK); endclocking
  default disable iff (SYS_RST);

  a_irq_set_wins: assert property (
    CORE_STAT.irq_set[0] |=> IRQ_FLAGS[0])
    else $error("irq event lost");
  a_irq_clear_one: assert property (
    irq_clr != 8'h00 && CORE_STAT.irq_set == 8'h00
    |=> IRQ_FLAGS == ($past(IRQ_FLAGS) & ~$past(irq_clr)))
    else $error("irq write did not clear");
  a_page_decode: assert property (
    wr_start && page == PMD_PG0 && HOST_ADDR == `PMD_OFS_RX_START
    |=> CFG.rx_start == $past(wd) && CFG.station == $past(CFG.station))
    else $error("page 0 write misrouted");
  a_station_write: assert property (
    wr_start && page == PMD_PG1 && HOST_ADDR == `PMD_OFS_STATION_FIRST
    |=> CFG.station[0] == $past(wd) && CFG.rx_start == $past(CFG.rx_start))
    else $error("station write misrouted");
  a_dp_narrow: assert property (
    rd_start && is_dp && !word_transfer_select |=> HOST_DATA_OUT[15:8] == 8'h00 && HOST_DATA_OE)
    else $error("narrow data port drove high byte");
  a_dp_wide: assert property (
    rd_start && is_dp && word_transfer_select |=> HOST_DATA_OUT == $past(dp_rdata) && DP_RD_STB)
    else $error("wide data port word wrong");
  a_dsr_read: assert property (
    rd_start && HOST_ADDR == `PMD_OFS_JAM |=> HOST_DATA_OUT == {8'h00, $past(dsr)})
    else $error("device state read wrong");
  a_jam_write: assert property (
    wr_start && HOST_ADDR == `PMD_OFS_JAM |=> CFG.jam == $past(wd))
    else $error("jam limit not stored");
  a_swrst_pulse: assert property (
    rd_start && HOST_ADDR == `PMD_OFS_WAKE |=> SOFT_RST_STB ##1 !SOFT_RST_STB)
    else $error("soft reset pulse wrong");
  a_wake_pulse: assert property (
    WAKE_STB |-> $past(wr_start) && $past(HOST_ADDR) == `PMD_OFS_WAKE)
    else $error("wake pulse without write");
  a_txs_read: assert property (
    rd_start && page == PMD_PG0 && HOST_ADDR == `PMD_OFS_TX_PAGE
    |=> HOST_DATA_OUT[7:0] == $past(txs))
    else $error("tx status read wrong");
  a_rsvd_zero: assert property (
    rd_start && (HOST_ADDR == `PMD_OFS_BYTE_ORDER || HOST_ADDR == `PMD_OFS_VLAN_HI)
    |=> HOST_DATA_OUT == 16'h0000)
    else $error("reserved read not zero");
  a_mfs_hi_nib: assert property (
    rd_start && HOST_ADDR == `PMD_OFS_MFS_HI |=> HOST_DATA_OUT[15:4] == 12'h000)
    else $error("frame size high read too wide");
  a_oe_hold: assert property (
    rd_start ##1 rd_req [*2] |-> HOST_DATA_OE && $stable(HOST_DATA_OUT))
    else $error("read data not held");
  a_oe_drop: assert property (
    !rd_req |=> !HOST_DATA_OE && HOST_DATA_OUT == 16'h0000)
    else $error("read data not released");

  c_wide_dp: cover property (rd_start && is_dp && word_transfer_select ##1 rd_req);
  c_page1_wr: cover property (wr_start && page == PMD_PG1);
  c_set_clear: cover property (irq_clr != 8'h00 && CORE_STAT.irq_set != 8'h00);
  c_swrst: cover property (rd_start && HOST_ADDR == `PMD_OFS_WAKE);
endmodule

/* File: bench/pmd_host.sv */
// pmd_host: behavioural host master on the local bus of the register map
// assumes the bench starts every access through wr and rd
`timescale 1ns/1ns
module pmd_host (
  // clock
  input wire logic CLOCK,
  // bus towards the device
  output logic HOST_CS_N,
  output logic HOST_RD_N,
  output logic HOST_WR_N,
  output logic [4:0] HOST_ADDR,
  output logic [15:0] HOST_DATA_IN,
  // read path
  input wire logic [15:0] HOST_DATA_OUT,
  input wire logic HOST_DATA_OE
);
  initial begin
    HOST_CS_N = 1'b1;
    HOST_RD_N = 1'b1;
    HOST_WR_N = 1'b1;
    HOST_ADDR = 5'h00;
    HOST_DATA_IN = 16'h0000;
  end
  // released data lines show the inverse, never the last value
  task automatic wr(input logic [4:0] a, input logic [15:0] d);
    @(posedge CLOCK);
    HOST_CS_N <= 1'b0;
    HOST_WR_N <= 1'b0;
    HOST_ADDR <= a;
    HOST_DATA_IN <= d;
    @(posedge CLOCK);
    HOST_CS_N <= 1'b1;
    HOST_WR_N <= 1'b1;
    HOST_DATA_IN <= ~d;
    @(posedge CLOCK);
  endtask
  // answer is fixed one cycle after the start edge; strobe stays low two more edges
  task automatic rd(input logic [4:0] a, output logic [15:0] d, output logic oe);
    @(posedge CLOCK);
    HOST_CS_N <= 1'b0;
    HOST_RD_N <= 1'b0;
    HOST_ADDR <= a;
    @(posedge CLOCK);
    @(negedge CLOCK);
    d = HOST_DATA_OUT;
    oe = HOST_DATA_OE;
    @(posedge CLOCK);
    @(posedge CLOCK);
    HOST_CS_N <= 1'b1;
    HOST_RD_N <= 1'b1;
    HOST_ADDR <= ~a;
    @(posedge CLOCK);
  endtask
endmodule

/* File: bench/pmd_regs_bench.sv */
// pmd_regs_bench: self-checking bench for the paged register map
// assumes pmd_host as bus master and core status driven from here
`timescale 1ns/1ns
module pmd_regs_bench;
  import pmd_pkg::*;
  logic CLOCK = 1'b0;
  logic SYS_RST = 1'b1;
  logic cs_n, rd_n, wr_n, oe, dp_wr, dp_rd, srst, wake;
  logic [4:0] addr;
  logic [15:0] din, dout, dp_wdata;
  logic [7:0] irq, rxp;
  pmd_stat_s stat = '0;
  pmd_cfg_s cfg;
  int fail_count = 0, comparisons = 0, cycles = 0;
  int n_rst = 0, n_wake = 0, n_dpw = 0, n_dpr = 0;
  always #10 CLOCK = ~CLOCK;
  pmd_host host (.CLOCK(CLOCK), .HOST_CS_N(cs_n), .HOST_RD_N(rd_n), .HOST_WR_N(wr_n),
    .HOST_ADDR(addr), .HOST_DATA_IN(din), .HOST_DATA_OUT(dout), .HOST_DATA_OE(oe));
  pmd_regs dut (.CLOCK(CLOCK), .SYS_RST(SYS_RST), .HOST_CS_N(cs_n), .HOST_RD_N(rd_n),
    .HOST_WR_N(wr_n), .HOST_ADDR(addr), .HOST_DATA_IN(din), .HOST_DATA_OUT(dout),
    .HOST_DATA_OE(oe), .CORE_STAT(stat), .CFG(cfg), .IRQ_FLAGS(irq), .RX_CUR_PAGE(rxp),
    .DP_WR_STB(dp_wr), .DP_WDATA(dp_wdata), .DP_RD_STB(dp_rd), .SOFT_RST_STB(srst),
    .WAKE_STB(wake));
  // strobe tallies and hang guard
  always @(posedge CLOCK) begin
    cycles++;
    if (srst === 1'b1) n_rst++;
    if (wake === 1'b1) n_wake++;
    if (dp_wr === 1'b1) n_dpw++;
    if (dp_rd === 1'b1) n_dpr++;
    if (cycles == 6000) begin
      fail_count++;
      final_report();
    end
  end
  task automatic chk(input string n, input logic [15:0] e, input logic [15:0] g);
    comparisons++;
    if (g !== e) begin
      fail_count++;
      $display("unexpected %s: expected %h seen %h", n, e, g);
    end
  endtask
  task automatic rdc(input logic [4:0] a, input logic [15:0] e, input string n);
    logic [15:0] d;
    logic o;
    host.rd(a, d, o);
    chk(n, e, d);
    chk({n, " oe"}, 16'h0001, {15'h0, o});
  endtask
  task automatic t_reset;
    chk("cfg command", 16'h0021, {8'h00, cfg.command});
    rdc(5'h00, 16'h0021, "command");
    rdc(5'h03, 16'h004C, "boundary");
    $display("test reset done");
  endtask
  task automatic t_common;
    for (int a = 18; a <= 27; a++) if (a != 23 && a != 25) begin
      host.wr(5'(a), {8'hA5, 8'(a)});
      rdc(5'(a), {8'h00, 8'(a)}, "unpaged reg");
    end
    host.wr(5'h19, 16'hFFFF);
    rdc(5'h19, 16'h000F, "max frame hi");
    chk("cfg mfs", 16'h0F18, {4'h0, cfg.mfs});
    $display("test common done");
  endtask
  task automatic t_split;
    int k;
    rdc(5'h17, 16'h0019, "device state");
    host.wr(5'h17, 16'h0077);
    chk("cfg jam", 16'h0077, {8'h00, cfg.jam});
    rdc(5'h1C, 16'h001A, "tx end page");
    host.wr(5'h1C, 16'h0031);
    host.wr(5'h1D, 16'h0032);
    chk("cfg vlan", 16'h3231, cfg.vlan);
    rdc(5'h1D, 16'h0000, "vlan hi read");
    host.wr(5'h1E, 16'h0033);
    chk("cfg byte order", 16'h0033, {8'h00, cfg.byte_order});
    rdc(5'h1E, 16'h0000, "byte order read");
    k = n_rst;
    rdc(5'h1F, 16'h0000, "soft reset read");
    chk("soft reset pulses", 16'h0001, 16'(n_rst - k));
    k = n_wake;
    host.wr(5'h1F, 16'h0044);
    @(negedge CLOCK);
    chk("wake pulses", 16'h0001, 16'(n_wake - k));
    $display("test split done");
  endtask
  task automatic t_page0;
    for (int a = 1; a <= 15; a++) if (a != 7) host.wr(5'(a), {8'hA5, 8'(8'h40 + a)});
    chk("ring start stop", 16'h4142, {cfg.rx_start, cfg.rx_stop});
    rdc(5'h01, 16'h0041, "ring start read");
    rdc(5'h03, 16'h0043, "boundary read");
    chk("tx page", 16'h0044, {8'h00, cfg.tx_page});
    chk("tx count", 16'h4645, cfg.tx_cnt);
    chk("remote start", 16'h4948, cfg.rem_start);
    chk("remote count", 16'h4B4A, cfg.rem_cnt);
    chk("rx tx cfg", 16'h4C4D, {cfg.rx_cfg, cfg.tx_cfg});
    chk("data cfg mask", 16'h4E4F, {cfg.data_cfg, cfg.irq_mask});
    rdc(5'h04, 16'h0011, "tx status");
    rdc(5'h05, 16'h0012, "collisions");
    rdc(5'h06, 16'h0000, "rx page view");
    rdc(5'h08, 16'h0013, "remote cur lo");
    rdc(5'h09, 16'h0014, "remote cur hi");
    rdc(5'h0A, 16'h0000, "reserved 0a");
    rdc(5'h0B, 16'h0000, "reserved 0b");
    for (int a = 12; a <= 15; a++) rdc(5'(a), 16'(a + 9), "rx status tally");
    $display("test page0 done");
  endtask
  task automatic t_irq;
    @(posedge CLOCK);
    stat.irq_set <= 8'h05;
    @(posedge CLOCK);
    stat.irq_set <= 8'h00;
    @(negedge CLOCK);
    chk("irq flags", 16'h0005, {8'h00, irq});
    rdc(5'h07, 16'h0005, "irq read");
    host.wr(5'h07, 16'h0001);
    rdc(5'h07, 16'h0004, "irq after clear");
    fork
      host.wr(5'h07, 16'h0001);
      begin
        @(posedge CLOCK);
        stat.irq_set <= 8'h01;
        @(posedge CLOCK);
        stat.irq_set <= 8'h00;
      end
    join
    rdc(5'h07, 16'h0005, "irq set beats clear");
    $display("test irq done");
  endtask
  task automatic t_pages;
    host.wr(5'h00, 16'h0061);
    for (int a = 1; a <= 15; a++) host.wr(5'(a), {8'h00, 8'(8'h80 + a)});
    chk("station first last", 16'h8186, {cfg.station[0], cfg.station[5]});
    chk("hash first last", 16'h888F, {cfg.mcast[0], cfg.mcast[7]});
    chk("rx cur page", 16'h0087, {8'h00, rxp});
    for (int a = 1; a <= 15; a++) rdc(5'(a), 16'(a + 128), "page1 reg");
    @(posedge CLOCK);
    stat.rx_page_val <= 8'h5A;
    stat.rx_page_load <= 1'b1;
    @(posedge CLOCK);
    stat.rx_page_load <= 1'b0;
    rdc(5'h07, 16'h005A, "rx page loaded");
    host.wr(5'h00, 16'h00A1);
    host.wr(5'h01, 16'h0055);
    rdc(5'h01, 16'h0000, "page2 read");
    chk("station kept", 16'h0081, {8'h00, cfg.station[0]});
    rdc(5'h12, 16'h0012, "unpaged in page2");
    host.wr(5'h00, 16'h00E1);
    rdc(5'h04, 16'h0000, "page3 read");
    host.wr(5'h00, 16'h0021);
    rdc(5'h04, 16'h0011, "page0 again");
    $display("test pages done");
  endtask
  task automatic t_dport;
    host.wr(5'h10, 16'hBEEF);
    chk("dp byte", 16'h00EF, {8'h00, dp_wdata[7:0]});
    rdc(5'h10, 16'h00FE, "dp byte read");
    host.wr(5'h0E, 16'h0001);
    host.wr(5'h11, 16'hBEEF);
    chk("dp word", 16'hBEEF, dp_wdata);
    rdc(5'h11, 16'hCAFE, "dp word read");
    chk("dp strobes", 16'h0202, {8'(n_dpw), 8'(n_dpr)});
    $display("test dport done");
  endtask
  task automatic final_report;
    $display("comparisons %0d fail_count %0d", comparisons, fail_count);
    if (fail_count == 0 && comparisons > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  initial begin
    stat.tx_status = 8'h11;
    stat.collisions = 8'h12;
    stat.rem_cur = 16'h1413;
    stat.rx_status = 8'h15;
    stat.align = 8'h16;
    stat.crc = 8'h17;
    stat.lost = 8'h18;
    stat.dev_state = 8'h19;
    stat.tx_end_page = 8'h1A;
    stat.dp_rdata = 16'hCAFE;
    repeat (10) @(posedge CLOCK);
    SYS_RST <= 1'b0;
    @(posedge CLOCK);
    t_reset();
    t_common();
    t_split();
    t_page0();
    t_irq();
    t_pages();
    t_dport();
    final_report();
  end
endmodule
